// ===== rtl/cmc_cache_ctrl.sv
// retry-on-miss direct-mapped write-through cache controller
//
// Chosen here: the register addresses and the APB interface to the registers.
`include "cmc_params.svh"
`default_nettype none
module cmc_cache_ctrl (
   input wire logic clk,
   input wire logic sysRst,
   input wire logic [31:0] addr,
   input wire logic [2:0] functionCodeBits,
   input wire logic [1:0] transferWidthBits,
   input wire logic addrStrobeN,
   input wire logic readCycle,
   input wire logic cpuWriteN,
   input wire logic ioRangeHit,
   input wire logic [1:0] sysAckN,
   input wire logic [31:0] dataIn,
   output logic [31:0] dataOut,
   output logic dataOe,
   output logic [1:0] dataTransferAckN,
   output logic busErrorOutN,
   output logic haltN,
   output logic missBufferEnable,
   output logic tagHit,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   import cmc_pkg::*;

   localparam cmc_state_t RST_STATE = '{
      phase: PH_IDLE,
      dsackN: `CMC_ACK_OFF,
      berrN: 1'b1,
      haltN: 1'b1,
      default: '0
   };

   cmc_state_t q;
   cmc_state_t d;

   logic [`CMC_KEY_W-1:0] tagMem [`CMC_DEPTH];
   logic [31:0] dataMem [`CMC_DEPTH];
   logic [1:0] validQ [`CMC_DEPTH];

   logic [`CMC_IDX_W-1:0] idx;
   logic [`CMC_KEY_W-1:0] tagKey;
   logic [`CMC_KEY_W-1:0] rdTag;
   logic [1:0] rdValid;
   logic [31:0] rdData;
   logic coprocSpaceCycle;
   logic rawMatch;
   logic clrBusy;
   logic qualHit;
   logic asLowNow;
   logic asTrail;
   logic cpuEn;
   logic memRd;
   logic cpuWr;
   logic updEnd;
   logic memWe;
   logic clrStart;
   logic cmdHit;
   cmc_cmd_t busCmd;
   logic apbAccess;
   logic apbWr;
   logic ackAllowed;
   logic cmdAck;
   logic errNow;

   // index straight from the logical address, key from its tag bits plus transfer width and function code
   assign idx = addr[`CMC_IDX_HI:`CMC_IDX_LO];
   assign tagKey = {addr[`CMC_TAG_HI:`CMC_TAG_LO], transferWidthBits,
      functionCodeBits};
   assign rdTag = tagMem[idx];
   assign rdValid = validQ[idx];
   assign rdData = dataMem[idx];
   assign coprocSpaceCycle = &functionCodeBits;
   assign clrBusy = (q.clrCnt != 2'h0);
   assign rawMatch = (rdTag == tagKey) &&
      (rdValid == `CMC_VALID_ONES);
   assign asLowNow = !addrStrobeN;
   assign asTrail = q.asLow && addrStrobeN;
   assign cpuEn = q.cpuDiv;
   assign apbAccess = psel && penable && q.pready;
   assign apbWr = apbAccess && pwrite && (paddr == `CMC_OFF_CTRL);

   always_comb begin
      busCmd = CMD_NONE;
      cmdHit = 1'b0;
      if (asLowNow && coprocSpaceCycle &&
            addr[`CMC_SPACE_HI:`CMC_SPACE_LO] == `CMC_CMD_SPACE) begin
         busCmd = cmc_cmd_t'(addr[`CMC_CMD_HI:`CMC_CMD_LO]);
         cmdHit = (busCmd != CMD_NONE);
      end
   end

   // hit qualification
   assign qualHit = rawMatch && !coprocSpaceCycle && !ioRangeHit &&
      q.cacheOn && asLowNow && !clrBusy;
   assign memRd = readCycle && q.cacheOn && !coprocSpaceCycle &&
      !ioRangeHit && !q.inhibit;
   assign cpuWr = asLowNow && !readCycle && !cpuWriteN &&
      !coprocSpaceCycle && !ioRangeHit;
   assign updEnd = q.upd && q.updAck && cpuEn &&
      (q.updCnt == 2'(`CMC_UPD_CPU_CLKS - 1));
   assign memWe = cpuWr || updEnd;
   assign ackAllowed = !sysRst && q.cacheOn && !q.inhibit;

   always_comb begin
      d = q;
      clrStart = 1'b0;
      d.asLow = asLowNow;
      d.cpuDiv = ~q.cpuDiv;

      // bus state tracking from the address strobe
      if (!asLowNow) begin
         d.phase = PH_IDLE;
      end else begin
         unique case (q.phase)
            PH_IDLE: d.phase = PH_S2;
            PH_S2: d.phase = PH_S3;
            PH_S3: d.phase = PH_S4;
            PH_S4: d.phase = PH_LATE;
            PH_LATE: d.phase = PH_LATE;
            default: d.phase = PH_IDLE;
         endcase
      end
      if (d.phase == PH_S2) begin
         d.cpuDiv = 1'b0;
      end

      // two-stage late sampling of the hit status
      if (q.phase == PH_S2) begin
         d.hit1 = qualHit;
      end
      if (q.phase == PH_S3 && cpuEn) begin
         d.missDet = memRd && !(q.hit1 && qualHit);
      end

      // response block across the refill cycle
      if (asTrail) begin
         d.inhibit = q.missDet;
         d.missDet = 1'b0;
      end
      d.missBuf = d.missDet || d.inhibit;

      // refill strobe during the update cycle
      if (!asLowNow) begin
         d.updDone = 1'b0;
         d.upd = 1'b0;
         d.updAck = 1'b0;
         d.updCnt = 2'h0;
      end else if (q.inhibit && !q.updDone && !q.upd) begin
         d.upd = 1'b1;
      end
      if (q.upd && sysAckN != `CMC_ACK_OFF) begin
         d.updAck = 1'b1;
      end
      if (q.upd && q.updAck && cpuEn) begin
         d.updCnt = q.updCnt + 2'h1;
      end
      if (updEnd) begin
         d.upd = 1'b0;
         d.updDone = 1'b1;
         d.updAck = 1'b0;
         d.updCnt = 2'h0;
      end

      // commands from processor space and from software
      if (q.phase == PH_IDLE && cmdHit) begin
         unique case (busCmd)
            CMD_EN: begin
               d.cacheOn = 1'b1;
               clrStart = 1'b1;
            end
            CMD_DIS: d.cacheOn = 1'b0;
            CMD_FLUSH: clrStart = 1'b1;
            CMD_NONE: d.cacheOn = q.cacheOn;
         endcase
      end
      if (apbWr) begin
         if (pwdata[`CMC_CTRL_EN]) begin
            d.cacheOn = 1'b1;
            clrStart = 1'b1;
         end else if (pwdata[`CMC_CTRL_DIS]) begin
            d.cacheOn = 1'b0;
         end
         if (pwdata[`CMC_CTRL_FLUSH]) begin
            clrStart = 1'b1;
         end
      end
      if (clrStart) begin
         d.clrCnt = 2'(`CMC_CLR_CYC);
      end else if (clrBusy) begin
         d.clrCnt = q.clrCnt - 2'h1;
      end

      // processor responses
      cmdAck = cmdHit && !sysRst && !(busCmd == CMD_FLUSH &&
         `CMC_FLUSH_WAIT && d.clrCnt != 2'h0);
      d.dsackN = `CMC_ACK_OFF;
      if (d.phase != PH_IDLE &&
            ((memRd && ackAllowed) || cmdAck)) begin
         d.dsackN = `CMC_ACK_ON;
      end
      errNow = asLowNow && !q.inhibit && ackAllowed && d.missDet &&
         (d.phase == PH_S4 || d.phase == PH_LATE);
      d.berrN = !errNow;
      d.haltN = !errNow;
      d.tagHit = qualHit;
      d.dataOe = qualHit && readCycle && !q.inhibit &&
         d.phase != PH_IDLE;
      d.dataOut = rdData;

      // register bus slave, zero wait states
      d.pready = 1'b0;
      d.pslverr = 1'b0;
      if (psel && !penable) begin
         d.pready = 1'b1;
         d.prdata = '0;
         if (paddr == `CMC_OFF_STAT) begin
            d.prdata[`CMC_ST_ON] = q.cacheOn;
            d.prdata[`CMC_ST_INH] = q.inhibit;
            d.prdata[`CMC_ST_CLR] = clrBusy;
            d.prdata[`CMC_ST_MISS] = q.missBuf;
         end else if (paddr != `CMC_OFF_CTRL) begin
            d.pslverr = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sysRst) begin
         q <= RST_STATE;
      end else begin
         q <= d;
      end
   end

   // tag key and data words, one long-word per line
   always_ff @(posedge clk) begin
      if (memWe) begin
         tagMem[idx] <= tagKey;
         dataMem[idx] <= dataIn;
      end
   end

   // valid pairs, cleared together by reset or tag clear
   for (genvar i = 0; i < `CMC_DEPTH; i++) begin : g_valid
      always_ff @(posedge clk) begin
         if (sysRst) begin
            validQ[i] <= `CMC_VALID_NONE;
         end else if (memWe && idx == `CMC_IDX_W'(i)) begin
            validQ[i] <= `CMC_VALID_ONES;
         end else if (clrStart || clrBusy) begin
            validQ[i] <= `CMC_VALID_NONE;
         end
      end
   end

   assign dataOut = q.dataOut;
   assign dataOe = q.dataOe;
   assign dataTransferAckN = q.dsackN;
   assign busErrorOutN = q.berrN;
   assign haltN = q.haltN;
   assign missBufferEnable = q.missBuf;
   assign tagHit = q.tagHit;
   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sysRst);

   a_err_halt_pair: assert property (
      busErrorOutN == haltN)
      else $error("error and halt differ");

   a_err_needs_strobe: assert property (
      !busErrorOutN |-> $past(asLowNow) && !$past(q.inhibit))
      else $error("error without strobe or while blocked");

   a_ack_before_err: assert property (
      $fell(busErrorOutN) |-> dataTransferAckN == `CMC_ACK_ON &&
      $past(dataTransferAckN) == `CMC_ACK_ON)
      else $error("error not preceded by acknowledge");

   a_off_no_ack: assert property (
      !$past(q.cacheOn) && !$past(cmdHit) |->
      dataTransferAckN == `CMC_ACK_OFF)
      else $error("acknowledge while cache off");

   a_block_sets: assert property (
      asTrail && q.missDet |=> q.inhibit ##1 !busErrorOutN == 1'b0)
      else $error("response block not set after miss");

   a_block_holds: assert property (
      q.inhibit && !asTrail |=> q.inhibit)
      else $error("response block dropped early");

   a_clear_time: assert property (
      clrStart |=> clrBusy ##1 clrBusy ##1 !clrBusy)
      else $error("tag clear length wrong");

   a_hit_gated: assert property (
      tagHit |-> $past(q.cacheOn) && !$past(coprocSpaceCycle) &&
      !$past(ioRangeHit) && $past(asLowNow))
      else $error("hit in a suppressed case");

   a_oe_on_hit: assert property (
      dataOe |-> tagHit)
      else $error("data driven without hit");

   a_refill_end: assert property (
      $rose(q.updAck) |-> ##[1:6] !q.upd)
      else $error("refill strobe too long");

   a_reset_off: assert property (
      $past(sysRst) |-> !q.cacheOn && !q.inhibit && !q.missDet)
      else $error("state not cleared by reset");

   a_update_no_ack: assert property (
      q.inhibit && !cmdHit |=> dataTransferAckN == `CMC_ACK_OFF)
      else $error("acknowledge during update cycle");

   a_write_no_ack: assert property (
      cpuWr |=> dataTransferAckN == `CMC_ACK_OFF)
      else $error("acknowledge during write cycle");

   a_miss_buffer: assert property (
      errNow |=> missBufferEnable)
      else $error("miss without buffer enable");

   a_cmd_ack: assert property (
      cmdHit && q.phase == PH_IDLE |=> dataTransferAckN == `CMC_ACK_ON)
      else $error("command not acknowledged");

   a_enable_clears: assert property (
      cmdHit && busCmd == CMD_EN && q.phase == PH_IDLE |-> clrStart)
      else $error("enable without tag clear");

   c_hit_read: cover property (dataOe && dataTransferAckN == `CMC_ACK_ON);
   c_retry: cover property ($fell(busErrorOutN));
   c_refill: cover property (updEnd);
   c_flush: cover property (cmdHit && busCmd == CMD_FLUSH);
   c_write: cover property (cpuWr);
endmodule
`default_nettype wire

// ===== rtl/cmc_params.svh
// constants for the retry-on-miss cache controller
`ifndef CMC_PARAMS_SVH
`define CMC_PARAMS_SVH

`define CMC_DEPTH 8192
`define CMC_IDX_W 13
`define CMC_IDX_LO 2
`define CMC_IDX_HI 14
`define CMC_TAG_LO 15
`define CMC_TAG_HI 31
`define CMC_KEY_W 22
`define CMC_VALID_ONES 2'h3
`define CMC_VALID_NONE 2'h0
`define CMC_ACK_ON 2'h0
`define CMC_ACK_OFF 2'h3

`define CMC_SPACE_LO 16
`define CMC_SPACE_HI 19
`define CMC_CMD_SPACE 4'hF
`define CMC_CMD_LO 2
`define CMC_CMD_HI 3

`define CMC_CLK_NS 25
`define CMC_CLR_NS 55
`define CMC_AS_MIN_NS 50
`define CMC_CLR_CYC ((`CMC_CLR_NS) / (`CMC_CLK_NS))
`define CMC_AS_CYC (((`CMC_AS_MIN_NS) + (`CMC_CLK_NS) - 1) / (`CMC_CLK_NS))
`define CMC_FLUSH_WAIT ((`CMC_CLR_CYC) > (`CMC_AS_CYC))
`define CMC_UPD_CPU_CLKS 2

`define CMC_OFF_CTRL 12'h000
`define CMC_OFF_STAT 12'h004
`define CMC_CTRL_EN 0
`define CMC_CTRL_DIS 1
`define CMC_CTRL_FLUSH 2
`define CMC_ST_ON 0
`define CMC_ST_INH 1
`define CMC_ST_CLR 2
`define CMC_ST_MISS 3

`endif

// ===== rtl/cmc_pkg.sv
// types for the retry-on-miss cache controller
`default_nettype none
package cmc_pkg;
   typedef enum logic [1:0] {
      CMD_NONE = 2'b00,
      CMD_EN = 2'b01,
      CMD_DIS = 2'b10,
      CMD_FLUSH = 2'b11
   } cmc_cmd_t;

   typedef enum logic [2:0] {
      PH_IDLE = 3'b000,
      PH_S2 = 3'b001,
      PH_S3 = 3'b010,
      PH_S4 = 3'b011,
      PH_LATE = 3'b100
   } cmc_phase_t;

   typedef struct packed {
      cmc_phase_t phase;
      logic asLow;
      logic cpuDiv;
      logic cacheOn;
      logic hit1;
      logic missDet;
      logic inhibit;
      logic [1:0] clrCnt;
      logic upd;
      logic updAck;
      logic [1:0] updCnt;
      logic updDone;
      logic [1:0] dsackN;
      logic berrN;
      logic haltN;
      logic missBuf;
      logic tagHit;
      logic [31:0] dataOut;
      logic dataOe;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } cmc_state_t;
endpackage
`default_nettype wire

// ===== testbench/cmc_mem_model.sv
// system memory model answering refill cycles
`default_nettype none
module cmc_mem_model #(
   parameter logic [31:0] REFILL = 32'h5A5A_C3C3
) (
   input wire logic clk,
   input wire logic sysRst,
   input wire logic addrStrobeN,
   input wire logic missBufferEnable,
   input wire logic [3:0] delay,
   output logic [1:0] sysAckN,
   output logic [31:0] memData
);
   timeunit 1ns;
   timeprecision 1ps;
   logic armed;
   logic strobeQ;
   logic [3:0] cnt;
   always_ff @(posedge clk) begin
      strobeQ <= addrStrobeN;
      if (sysRst) begin
         armed <= 1'b0;
      end else if (addrStrobeN && !strobeQ) begin
         armed <= missBufferEnable && !armed;
      end
      if (sysRst || addrStrobeN || !armed) begin
         cnt <= 4'h0;
         sysAckN <= 2'h3;
      end else if (cnt == delay) begin
         sysAckN <= 2'h0;
      end else begin
         cnt <= cnt + 4'h1;
      end
   end
   // released bus shows the inverse of the refill word
   assign memData = (sysAckN == 2'h0) ? REFILL : ~REFILL;
endmodule
`default_nettype wire

// ===== testbench/retry_miss_cache_controller_tb.sv
// bench for the retry-on-miss cache controller
`default_nettype none
module retry_miss_cache_controller_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] MEMD = 32'h5A5A_C3C3;
   localparam logic [31:0] A = 32'h1234_5678;
   localparam logic [31:0] B = 32'h0000_1004;
   logic clk, rst, addrStrobeN, readCycle, cpuWriteN, ioRangeHit;
   logic [31:0] addr, dataIn, wdata, memData, dataOut, prdata, pwdata, rdat;
   logic [2:0] functionCodeBits;
   logic [1:0] transferWidthBits, sysAckN, dataTransferAckN;
   logic dataOe, busErrorOutN, haltN, missBufferEnable, tagHit;
   logic psel, penable, pwrite, pready, pslverr, rerr;
   logic [11:0] paddr;
   logic [3:0] memDelay;
   logic sAck, sErr, sHit, sMb;
   logic [31:0] sDat;
   int n_mismatch = 0;
   int checked = 0;
   assign dataIn = cpuWriteN ? memData : wdata;
   cmc_cache_ctrl uut (.clk(clk), .sysRst(rst), .addr(addr),
      .functionCodeBits(functionCodeBits),
      .transferWidthBits(transferWidthBits), .addrStrobeN(addrStrobeN),
      .readCycle(readCycle), .cpuWriteN(cpuWriteN),
      .ioRangeHit(ioRangeHit), .sysAckN(sysAckN), .dataIn(dataIn),
      .dataOut(dataOut), .dataOe(dataOe),
      .dataTransferAckN(dataTransferAckN), .busErrorOutN(busErrorOutN),
      .haltN(haltN), .missBufferEnable(missBufferEnable), .tagHit(tagHit),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   cmc_mem_model #(.REFILL(MEMD)) mem (.clk(clk), .sysRst(rst),
      .addrStrobeN(addrStrobeN), .missBufferEnable(missBufferEnable),
      .delay(memDelay), .sysAckN(sysAckN), .memData(memData));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic summarize;
      $display("mismatches %0d checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // one processor cycle with strobe low for len + 1 edges, outputs sampled on the first len
   task automatic cyc(input logic [31:0] a, input logic [2:0] fc,
      input logic rd, input logic io, input int len);
      {sAck, sErr, sHit, sMb} = 4'h0;
      sDat = 32'h0;
      @(posedge clk);
      addr <= a;
      functionCodeBits <= fc;
      readCycle <= rd;
      ioRangeHit <= io;
      addrStrobeN <= 1'b0;
      cpuWriteN <= rd;
      repeat (len) begin
         @(posedge clk);
         #1;
         if (dataTransferAckN === 2'h0) sAck = 1'b1;
         if (busErrorOutN === 1'b0 && haltN === 1'b0) sErr = 1'b1;
         if (tagHit === 1'b1) sHit = 1'b1;
         if (missBufferEnable === 1'b1) sMb = 1'b1;
         if (dataOe === 1'b1) sDat = dataOut;
      end
      @(posedge clk);
      addrStrobeN <= 1'b1;
      cpuWriteN <= 1'b1;
      repeat (2) @(posedge clk);
   endtask
   task automatic tReset;
      @(posedge clk);
      #1;
      chk(32'(dataTransferAckN), 32'h3);
      chk(32'(tagHit), 32'h0);
      apb(1'b0, 12'h004, 32'h0);
      chk(rdat, 32'h0);
      apb(1'b0, 12'h010, 32'h0);
      chk(32'(rerr), 32'h1);
      cyc(A, 3'h1, 1'b1, 1'b0, 5);
      chk(32'(sAck), 32'h0);
      chk(32'(sHit), 32'h0);
   endtask
   task automatic tMiss;
      cyc(32'h000F_0004, 3'h7, 1'b1, 1'b0, 5);
      chk(32'(sAck), 32'h1);
      cyc(A, 3'h1, 1'b1, 1'b0, 5);
      chk(32'(sAck), 32'h1);
      chk(32'(sErr), 32'h1);
      chk(32'(sMb), 32'h1);
      chk(32'(sHit), 32'h0);
      apb(1'b0, 12'h004, 32'h0);
      chk(rdat, 32'h0000_000B);
      cyc(A, 3'h1, 1'b1, 1'b0, 12);
      chk(32'(sAck), 32'h0);
      cyc(A, 3'h1, 1'b1, 1'b0, 5);
      chk(32'(sHit), 32'h1);
      chk(sDat, MEMD);
      chk(32'(sErr), 32'h0);
      chk(32'(sMb), 32'h0);
   endtask
   task automatic tWrite;
      wdata <= 32'hC0DE_0F0F;
      cyc(B, 3'h1, 1'b0, 1'b0, 5);
      chk(32'(sAck), 32'h0);
      cyc(B, 3'h1, 1'b1, 1'b0, 5);
      chk(32'(sHit), 32'h1);
      chk(sDat, 32'hC0DE_0F0F);
   endtask
   task automatic tFc;
      memDelay <= 4'h4;
      cyc(A, 3'h2, 1'b1, 1'b0, 5);
      chk(32'(sErr), 32'h1);
      cyc(A, 3'h2, 1'b1, 1'b0, 12);
      cyc(A, 3'h2, 1'b1, 1'b0, 5);
      chk(32'(sHit), 32'h1);
      cyc(A, 3'h1, 1'b1, 1'b0, 5);
      chk(32'(sErr), 32'h1);
      cyc(A, 3'h1, 1'b1, 1'b0, 12);
      cyc(A, 3'h1, 1'b1, 1'b1, 5);
      chk(32'(sHit), 32'h0);
      chk(32'(sAck), 32'h0);
      cyc(A, 3'h7, 1'b1, 1'b0, 5);
      chk(32'(sHit), 32'h0);
   endtask
   task automatic tFlush;
      apb(1'b1, 12'h000, 32'h4);
      cyc(A, 3'h1, 1'b1, 1'b0, 5);
      chk(32'(sErr), 32'h1);
      cyc(A, 3'h1, 1'b1, 1'b0, 12);
      cyc(32'h000F_000C, 3'h7, 1'b1, 1'b0, 5);
      chk(32'(sAck), 32'h1);
      cyc(B, 3'h1, 1'b1, 1'b0, 5);
      chk(32'(sErr), 32'h1);
      cyc(B, 3'h1, 1'b1, 1'b0, 12);
      cyc(32'h000F_0008, 3'h7, 1'b1, 1'b0, 5);
      chk(32'(sAck), 32'h1);
      cyc(B, 3'h1, 1'b1, 1'b0, 5);
      chk(32'(sAck), 32'h0);
      apb(1'b0, 12'h004, 32'h0);
      chk(32'(rdat[0]), 32'h0);
   endtask
   task automatic tMidReset;
      apb(1'b1, 12'h000, 32'h1);
      apb(1'b0, 12'h004, 32'h0);
      chk(rdat, 32'h5);
      apb(1'b1, 12'h000, 32'h2);
      apb(1'b0, 12'h004, 32'h0);
      chk(rdat, 32'h0);
      apb(1'b1, 12'h000, 32'h1);
      cyc(A, 3'h1, 1'b1, 1'b0, 5);
      chk(32'(sErr), 32'h1);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      chk(32'(missBufferEnable), 32'h0);
      apb(1'b0, 12'h004, 32'h0);
      chk(rdat, 32'h0);
      cyc(A, 3'h1, 1'b1, 1'b0, 5);
      chk(32'(sAck), 32'h0);
   endtask
   initial begin
      rst = 1'b1;
      addr = 32'h0;
      functionCodeBits = 3'h0;
      transferWidthBits = 2'h0;
      addrStrobeN = 1'b1;
      readCycle = 1'b1;
      cpuWriteN = 1'b1;
      ioRangeHit = 1'b0;
      wdata = 32'h0;
      memDelay = 4'h1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      tReset();
      tMiss();
      tWrite();
      tFc();
      tFlush();
      tMidReset();
      summarize();
   end
   initial begin
      #(25 * 20000);
      n_mismatch++;
      summarize();
   end
endmodule
`default_nettype wire
